// ---- verilog/cpual_pkg.sv ----
// Shared constants and types for the execution block of a 16-bit core.
// Assumes the sequencer drives opcodes of cpual_op_e and an APB master on the same clock.
package cpual_pkg;
  localparam logic [11:0] CPUAL_CTRL_OFS = 12'h000;
  localparam logic [11:0] CPUAL_STAT_OFS = 12'h004;
  localparam logic [11:0] CPUAL_RES_OFS = 12'h008;
  localparam int CTRL_GUARD_BIT = 0;
  localparam logic CTRL_GUARD_RST = 1'b0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_GUARD_BIT = 1;
  localparam int STAT_FLG_LSB = 2;
  localparam int STAT_HOLD_BIT = 7;
  localparam int STAT_SHARED_BIT = 8;
  localparam int STAT_SPACE_V_BIT = 9;
  localparam int STAT_SPACE_LSB = 10;
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int FLG_T = 4;
  localparam logic [4:0] FM_NZV = 5'h0e;
  localparam logic [4:0] FM_NZVC = 5'h0f;
  localparam logic [4:0] FM_NZ = 5'h0c;
  localparam logic [4:0] FM_Z = 5'h04;
  localparam logic [4:0] FM_T = 5'h10;
  localparam logic [5:0] INCDEC_BW_CYC = 6'h02;
  localparam logic [5:0] INCDEC_L_CYC = 6'h04;
  localparam logic [5:0] CMP_BW_CYC = 6'h02;
  localparam logic [5:0] CMP_L_CYC = 6'h03;
  localparam logic [5:0] LOGIC_L_CYC = 6'h05;
  localparam logic [5:0] NORM_BASE_CYC = 6'h05;
  localparam logic [5:0] SCAN1_ZERO_CYC = 6'h03;
  localparam logic [5:0] SCAN1_SET_CYC = 6'h05;
  localparam logic [5:0] SCAN2_ZERO_CYC = 6'h04;
  localparam logic [5:0] SCAN2_SET_CYC = 6'h06;
  localparam logic [5:0] SCAN4_ZERO_CYC = 6'h05;
  localparam logic [5:0] SCAN4_SET_CYC = 6'h07;
  localparam logic [5:0] GUARD_CYC = 6'h02;
  localparam logic [5:0] PREFIX_CYC = 6'h01;
  localparam logic [5:0] BANK_FAST_CYC = 6'h01;
  localparam logic [5:0] BANK_DATA_CYC = 6'h02;
  localparam logic [5:0] BANK_PAGE_CYC = 6'h03;
  typedef enum logic [3:0] {
    OP_ADD_ONE, OP_SUB_ONE, OP_COMPARE, OP_LONG_AND, OP_LONG_OR, OP_LONG_XOR,
    OP_NORMALIZE, OP_SCAN_INDEX, OP_SCAN_DOUBLED, OP_SCAN_QUAD,
    OP_GUARD_ON, OP_GUARD_OFF, OP_FLAG_HOLD, OP_SHARED_BANK, OP_SPACE_PREFIX, OP_MOV_BANK
  } cpual_op_e;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} cpual_size_e;
  typedef enum logic [1:0] {SP_EXTRA_DATA, SP_DATA, SP_PROGRAM, SP_STACK} cpual_space_e;
  typedef enum logic [2:0] {
    BR_PROGRAM, BR_EXTRA_DATA, BR_SYS_STACK, BR_USER_STACK, BR_STACK, BR_DATA, BR_DIRECT_PAGE
  } cpual_breg_e;
  typedef enum logic {ST_IDLE, ST_RUN} cpual_st_e;
endpackage : cpual_pkg

// ---- verilog/cpual_core.sv ----
// Execution block: add/subtract one, compare, long logic, normalize, bit scan,
// stack guard control, prefixes and bank register moves, with an APB register slave.
// Assumes the sequencer, operand path and APB master all run on clock.
// Function
// [RULE1] Add or subtract one writes back, updates N Z V, keeps C, locks memory.
// [RULE2] Compare subtracts operand from accumulator, stores nothing, updates N Z V C.
// [RULE3] Long and/or/xor store accumulator, set N Z, clear V, keep C, 5 cycles.
// [RULE4] Normalize shifts accumulator left to top set bit, count to register zero.
// [RULE5] Normalize takes 5 cycles when zero, else 5 plus shift count.
// [RULE6] Bit scan puts set bit position into low byte, Z updated, 3 or 5.
// [RULE7] Doubled bit scan returns position times two, 4 or 6 cycles.
// [RULE8] Quadrupled bit scan returns position times four, 5 or 7 cycles.
// [RULE9] Guard on and off instructions take 2 cycles and change no flags.
// [RULE10] Flag hold prefix, one cycle, stops next instruction changing flags.
// [RULE11] Shared bank prefix, one cycle, makes next instruction use common bank.
// [RULE12] Space prefixes, one cycle, redirect next memory access to chosen space.
// [RULE13] Bank register moves take 1, 2 for data, 3 for direct page.
// [RULE14] Memory forms add the operand path's correction cycles to the count.
// [RULE15] Overflow on signed wrap of the size; zero when masked result is zero.
`timescale 1ns/100ps
module cpual_core (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  input wire cpual_pkg::cpual_op_e op_code,
  input wire cpual_pkg::cpual_size_e op_size,
  input wire logic op_mem,
  input wire logic [3:0] op_corr,
  input wire logic [31:0] op_acc,
  input wire logic [31:0] op_src,
  input wire cpual_pkg::cpual_space_e op_space,
  input wire cpual_pkg::cpual_breg_e op_breg,
  input wire logic [7:0] op_bval,
  output logic op_ready,
  output logic op_done,
  output logic [31:0] res_data,
  output logic res_we,
  output logic [7:0] greg0_data,
  output logic greg0_we,
  output logic [4:0] flag_val,
  output logic [4:0] flag_we,
  output logic rmw_lock,
  output logic space_valid,
  output cpual_pkg::cpual_space_e space_sel,
  output logic shared_bank,
  output logic stack_guard_en
);
  import cpual_pkg::*;

  typedef struct packed {
    cpual_st_e st;
    logic [5:0] cnt;
    cpual_op_e op;
    logic done;
    logic [31:0] res;
    logic res_we;
    logic res_we_p;
    logic [7:0] g0;
    logic g0_we;
    logic g0_we_p;
    logic [4:0] fv;
    logic [4:0] fwe;
    logic [4:0] fwe_p;
    logic hold_p;
    logic shared_p;
    logic space_p;
    cpual_space_e space_p_sel;
    logic space_v;
    cpual_space_e space;
    logic shared;
    logic lock;
    logic guard;
    logic ready;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } cpual_state_s;

  localparam cpual_state_s RST = '{st: ST_IDLE, op: OP_ADD_ONE, space_p_sel: SP_EXTRA_DATA,
    space: SP_EXTRA_DATA, guard: CTRL_GUARD_RST, ready: 1'b1, default: '0};

  cpual_state_s state_reg;
  cpual_state_s state_next;

  function automatic logic [5:0] lead_zeros(input logic [31:0] x);
    logic [5:0] k;
    k = 6'h20;
    for (int i = 0; i < 32; i++) begin
      if (x[i]) k = 6'(31 - i);
    end
    return k;
  endfunction : lead_zeros

  function automatic logic [3:0] top_pos(input logic [15:0] x);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (x[i]) p = 4'(i);
    end
    return p;
  endfunction : top_pos

  logic take;
  logic [31:0] mask;
  logic [31:0] topbit;
  logic [31:0] am;
  logic [31:0] bm;
  logic [31:0] step;
  logic [32:0] diff;
  logic [31:0] dr;
  logic [5:0] lz;
  logic [3:0] pos;
  logic wzero;
  logic [5:0] cyc;

  assign take = op_valid && state_reg.ready;

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.res_we = 1'b0;
    state_next.g0_we = 1'b0;
    state_next.fwe = 5'h00;
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    state_next.prdata = 32'h0;
    cyc = PREFIX_CYC;
    case (op_size)
      SZ_BYTE: mask = 32'h000000ff;
      SZ_WORD: mask = 32'h0000ffff;
      default: mask = 32'hffffffff;
    endcase
    topbit = mask ^ (mask >> 1);
    am = op_acc & mask;
    bm = op_src & mask;
    // Step result is masked so a byte or word increment wrap reads as zero and a decrement wrap reads as all ones.
    step = ((op_code == OP_ADD_ONE) ? (bm + 32'h1) : (bm - 32'h1)) & mask; // [RULE15]
    diff = {1'b0, am} - {1'b0, bm}; // [RULE2]
    dr = diff[31:0] & mask;
    lz = lead_zeros(op_acc);
    pos = top_pos(op_acc[15:0]);
    wzero = (op_acc[15:0] == 16'h0);

    if (take) begin
      state_next.st = ST_RUN;
      state_next.ready = 1'b0;
      state_next.op = op_code;
      state_next.res_we_p = 1'b0;
      state_next.g0_we_p = 1'b0;
      state_next.fwe_p = 5'h00;
      state_next.fv = 5'h00;
      case (op_code)
        OP_ADD_ONE, OP_SUB_ONE: begin
          cyc = (op_size == SZ_LONG) ? INCDEC_L_CYC : INCDEC_BW_CYC;
          state_next.res = step; // [RULE1]
          state_next.res_we_p = 1'b1;
          state_next.fwe_p = FM_NZV; // [RULE1]
          state_next.fv[FLG_N] = |(step & topbit);
          state_next.fv[FLG_Z] = (step == 32'h0); // [RULE15]
          state_next.fv[FLG_V] = (op_code == OP_ADD_ONE) ? (bm == (mask >> 1)) : (bm == topbit);
          state_next.lock = op_mem; // [RULE1]
        end
        OP_COMPARE: begin
          cyc = (op_size == SZ_LONG) ? CMP_L_CYC : CMP_BW_CYC;
          state_next.res = dr;
          state_next.fwe_p = FM_NZVC; // [RULE2]
          state_next.fv[FLG_N] = |(dr & topbit);
          state_next.fv[FLG_Z] = (dr == 32'h0);
          state_next.fv[FLG_V] = (|(am & topbit) != |(bm & topbit)) &&
                                 (|(dr & topbit) != |(am & topbit));
          state_next.fv[FLG_C] = diff[32];
        end
        OP_LONG_AND, OP_LONG_OR, OP_LONG_XOR: begin
          cyc = LOGIC_L_CYC; // [RULE3]
          case (op_code)
            OP_LONG_AND: state_next.res = op_acc & op_src;
            OP_LONG_OR: state_next.res = op_acc | op_src;
            default: state_next.res = op_acc ^ op_src;
          endcase
          state_next.res_we_p = 1'b1;
          state_next.fwe_p = FM_NZV; // [RULE3]
          state_next.fv[FLG_N] = state_next.res[31];
          state_next.fv[FLG_Z] = (state_next.res == 32'h0);
        end
        OP_NORMALIZE: begin
          // A zero accumulator reports a zero count and stays zero.
          if (op_acc == 32'h0) begin
            cyc = NORM_BASE_CYC; // [RULE5]
            state_next.res = 32'h0;
            state_next.g0 = 8'h00;
            state_next.fv[FLG_T] = 1'b1;
          end else begin
            cyc = NORM_BASE_CYC + lz; // [RULE5]
            state_next.res = op_acc << lz[4:0]; // [RULE4]
            state_next.g0 = {2'b00, lz}; // [RULE4]
          end
          state_next.res_we_p = 1'b1;
          state_next.g0_we_p = 1'b1;
          state_next.fwe_p = FM_T; // [RULE4]
        end
        OP_SCAN_INDEX, OP_SCAN_DOUBLED, OP_SCAN_QUAD: begin
          case (op_code)
            OP_SCAN_INDEX: begin
              cyc = wzero ? SCAN1_ZERO_CYC : SCAN1_SET_CYC; // [RULE6]
              state_next.res = {op_acc[31:16], 8'h00, 4'h0, pos}; // [RULE6]
            end
            OP_SCAN_DOUBLED: begin
              cyc = wzero ? SCAN2_ZERO_CYC : SCAN2_SET_CYC; // [RULE7]
              state_next.res = {op_acc[31:16], 8'h00, 3'h0, pos, 1'b0}; // [RULE7]
            end
            default: begin
              cyc = wzero ? SCAN4_ZERO_CYC : SCAN4_SET_CYC; // [RULE8]
              state_next.res = {op_acc[31:16], 8'h00, 2'h0, pos, 2'h0}; // [RULE8]
            end
          endcase
          state_next.res_we_p = 1'b1;
          state_next.fwe_p = FM_Z; // [RULE6]
          state_next.fv[FLG_Z] = wzero;
        end
        OP_GUARD_ON, OP_GUARD_OFF: cyc = GUARD_CYC; // [RULE9]
        OP_FLAG_HOLD: state_next.hold_p = 1'b1; // [RULE10]
        OP_SHARED_BANK: state_next.shared_p = 1'b1; // [RULE11]
        OP_SPACE_PREFIX: begin
          state_next.space_p = 1'b1; // [RULE12]
          state_next.space_p_sel = op_space;
        end
        OP_MOV_BANK: begin
          case (op_breg)
            BR_DATA: cyc = BANK_DATA_CYC; // [RULE13]
            BR_DIRECT_PAGE: cyc = BANK_PAGE_CYC; // [RULE13]
            default: cyc = BANK_FAST_CYC; // [RULE13]
          endcase
          state_next.res = {op_acc[31:16], 8'h00, op_bval};
          state_next.res_we_p = 1'b1;
          state_next.fwe_p = FM_NZ;
          state_next.fv[FLG_N] = op_bval[7];
          state_next.fv[FLG_Z] = (op_bval == 8'h00);
        end
        default: cyc = PREFIX_CYC;
      endcase
      if (op_mem && op_code inside {OP_ADD_ONE, OP_SUB_ONE, OP_COMPARE,
          OP_LONG_AND, OP_LONG_OR, OP_LONG_XOR}) begin
        cyc = cyc + {2'b00, op_corr}; // [RULE14]
      end
      // Prefixes stack up; the first real instruction consumes all of them.
      if (!(op_code inside {OP_FLAG_HOLD, OP_SHARED_BANK, OP_SPACE_PREFIX})) begin
        if (state_reg.hold_p) state_next.fwe_p = 5'h00; // [RULE10]
        state_next.shared = state_reg.shared_p; // [RULE11]
        state_next.space_v = state_reg.space_p; // [RULE12]
        state_next.space = state_reg.space_p_sel;
        state_next.hold_p = 1'b0;
        state_next.shared_p = 1'b0;
        state_next.space_p = 1'b0;
      end
      state_next.cnt = cyc - 6'h01;
    end

    case (state_reg.st)
      ST_IDLE: ;
      ST_RUN: begin
        if (state_reg.cnt == 6'h00) begin
          state_next.st = ST_IDLE;
          state_next.ready = 1'b1;
          state_next.done = 1'b1;
          state_next.res_we = state_reg.res_we_p;
          state_next.g0_we = state_reg.g0_we_p;
          state_next.fwe = state_reg.fwe_p;
          state_next.lock = 1'b0;
          state_next.space_v = 1'b0;
          state_next.shared = 1'b0;
        end else begin
          state_next.cnt = state_reg.cnt - 6'h01;
        end
      end
      default: state_next.st = ST_IDLE;
    endcase

    // Zero-wait APB: decode in setup, answer in the first access cycle.
    if (psel && !penable) begin
      state_next.pready = 1'b1;
      case (paddr)
        CPUAL_CTRL_OFS: state_next.prdata[CTRL_GUARD_BIT] = state_reg.guard;
        CPUAL_STAT_OFS: begin
          state_next.prdata[STAT_BUSY_BIT] = (state_reg.st == ST_RUN);
          state_next.prdata[STAT_GUARD_BIT] = state_reg.guard;
          state_next.prdata[STAT_FLG_LSB +: 5] = state_reg.fv;
          state_next.prdata[STAT_HOLD_BIT] = state_reg.hold_p;
          state_next.prdata[STAT_SHARED_BIT] = state_reg.shared_p;
          state_next.prdata[STAT_SPACE_V_BIT] = state_reg.space_p;
          state_next.prdata[STAT_SPACE_LSB +: 2] = state_reg.space_p_sel;
        end
        CPUAL_RES_OFS: state_next.prdata = state_reg.res;
        default: state_next.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && state_reg.pready && pwrite && paddr == CPUAL_CTRL_OFS) begin
      state_next.guard = pwdata[CTRL_GUARD_BIT];
    end
    // The instruction wins over a software write landing on the same edge.
    if (state_reg.st == ST_RUN && state_reg.cnt == 6'h00) begin
      if (state_reg.op == OP_GUARD_ON) state_next.guard = 1'b1; // [RULE9]
      if (state_reg.op == OP_GUARD_OFF) state_next.guard = 1'b0; // [RULE9]
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= RST;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign op_ready = state_reg.ready;
  assign op_done = state_reg.done;
  assign res_data = state_reg.res;
  assign res_we = state_reg.res_we;
  assign greg0_data = state_reg.g0;
  assign greg0_we = state_reg.g0_we;
  assign flag_val = state_reg.fv;
  assign flag_we = state_reg.fwe;
  assign rmw_lock = state_reg.lock;
  assign space_valid = state_reg.space_v;
  assign space_sel = state_reg.space;
  assign shared_bank = state_reg.shared;
  assign stack_guard_en = state_reg.guard;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_step_keeps_carry: assert property (op_done && state_reg.op inside {OP_ADD_ONE, OP_SUB_ONE}
    |-> !flag_we[FLG_C] && (res_we || 1'b0)) else $error("step op touched carry or lost write"); // [RULE1]
  a_step_mem_lock: assert property (take && op_mem && op_code == OP_ADD_ONE
    |=> rmw_lock until op_done) else $error("memory step not locked"); // [RULE1]
  a_compare_no_store: assert property (op_done && state_reg.op == OP_COMPARE
    |-> !res_we) else $error("compare stored its difference"); // [RULE2]
  a_logic_five_cyc: assert property (take && op_code == OP_LONG_XOR && !op_mem
    |-> ##6 op_done && flag_we[FLG_V] && !flag_val[FLG_V]) else $error("long logic timing"); // [RULE3]
  a_norm_zero_time: assert property (take && op_code == OP_NORMALIZE && op_acc == 32'h0
    |-> ##6 op_done && greg0_data == 8'h00 && flag_we == FM_T) else $error("normalize zero"); // [RULE5]
  a_norm_top_bit: assert property (op_done && state_reg.op == OP_NORMALIZE && greg0_we
    && res_data != 32'h0 |-> res_data[31]) else $error("normalize left top bit clear"); // [RULE4]
  a_scan_zero_time: assert property (take && op_code == OP_SCAN_INDEX && op_acc[15:0] == 16'h0
    |-> ##4 op_done && flag_val[FLG_Z]) else $error("scan zero timing"); // [RULE6]
  a_scan_quad_time: assert property (take && op_code == OP_SCAN_QUAD && op_acc[15:0] != 16'h0
    |-> ##8 op_done && res_data[1:0] == 2'h0) else $error("quad scan timing"); // [RULE8]
  a_scan_dbl_time: assert property (take && op_code == OP_SCAN_DOUBLED && op_acc[15:0] == 16'h0
    |-> ##5 op_done) else $error("doubled scan timing"); // [RULE7]
  a_guard_no_flags: assert property (take && op_code == OP_GUARD_ON
    |-> ##3 op_done && flag_we == 5'h00 ##1 stack_guard_en) else $error("guard on"); // [RULE9]
  a_hold_blocks_flags: assert property (take && op_code == OP_FLAG_HOLD ##3 take
    |-> ##[1:60] op_done ##0 flag_we == 5'h00) else $error("flag hold ignored"); // [RULE10]
  a_prefix_one_cyc: assert property (take && op_code == OP_SPACE_PREFIX
    |-> ##2 op_done && !space_valid) else $error("prefix timing"); // [RULE12]
  a_shared_applied: assert property (take && state_reg.shared_p && op_code == OP_ADD_ONE
    |=> shared_bank) else $error("shared bank not applied"); // [RULE11]
  a_bank_page_cyc: assert property (take && op_code == OP_MOV_BANK && op_breg == BR_DIRECT_PAGE
    |-> ##4 op_done) else $error("direct page move timing"); // [RULE13]
  a_apb_zero_wait: assert property (psel && !penable |=> pready)
    else $error("apb not ready in access");

  c_norm_shift: cover property (take && op_code == OP_NORMALIZE && op_acc[31:28] == 4'h0);
  c_mem_step: cover property (take && op_mem && op_code == OP_SUB_ONE ##[2:40] op_done);
  c_prefix_then_op: cover property (take && op_code == OP_SPACE_PREFIX ##[2:4] take);
  c_apb_write: cover property (psel && penable && pready && pwrite);
endmodule : cpual_core

// ---- tb/cpual_seq_model.sv ----
// Sequencer and operand path model: presents one instruction per call of issue.
// Assumes the core's take handshake on clock; operands are garbled once taken.
`timescale 1ns/100ps
module cpual_seq_model (
  input wire logic clock,
  input wire logic op_ready,
  input wire logic op_done,
  input wire logic rmw_lock,
  input wire logic shared_bank,
  input wire logic space_valid,
  input wire cpual_pkg::cpual_space_e space_sel,
  output logic op_valid,
  output cpual_pkg::cpual_op_e op_code,
  output cpual_pkg::cpual_size_e op_size,
  output logic op_mem,
  output logic [3:0] op_corr,
  output logic [31:0] op_acc,
  output logic [31:0] op_src,
  output cpual_pkg::cpual_space_e op_space,
  output cpual_pkg::cpual_breg_e op_breg,
  output logic [7:0] op_bval
);
  import cpual_pkg::*;
  initial begin
    op_valid = 1'b0;
    op_code = OP_ADD_ONE;
    op_size = SZ_BYTE;
    op_mem = 1'b0;
    op_corr = 4'h0;
    op_acc = 32'h0;
    op_src = 32'h0;
    op_space = SP_DATA;
    op_breg = BR_PROGRAM;
    op_bval = 8'h00;
  end
  // Byte v doubles as space code, bank id and bank value to keep the call short.
  // Seen holds {space, lock, shared, space valid} observed while executing.
  task automatic issue(input cpual_op_e c, input cpual_size_e s, input logic m,
    input logic [3:0] k, input logic [31:0] a, input logic [31:0] b, input logic [7:0] v,
    output int cyc, output logic [4:0] seen);
    int i;
    cyc = -1;
    seen = 5'h00;
    op_valid <= 1'b1;
    op_code <= c;
    op_size <= s;
    op_mem <= m;
    op_corr <= k;
    op_acc <= a;
    op_src <= b;
    op_space <= cpual_space_e'(v[1:0]);
    op_breg <= cpual_breg_e'(v[2:0]);
    op_bval <= v;
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      if (op_ready === 1'b1) break;
    end
    if (i == 16) return;
    op_valid <= 1'b0;
    op_acc <= ~a;
    op_src <= ~b;
    op_bval <= ~v;
    for (i = 0; i < 48; i++) begin
      @(posedge clock);
      seen[2:0] = seen[2:0] | {rmw_lock, shared_bank, space_valid};
      if (space_valid === 1'b1) seen[4:3] = space_sel;
      if (op_done === 1'b1) begin
        cyc = i;
        break;
      end
    end
  endtask : issue
endmodule : cpual_seq_model

// ---- tb/testbench.sv ----
// Self-checking bench for the execution block, one task per scenario.
// Assumes cpual_seq_model drives the instruction port and this module the APB port.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
  import cpual_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, res_data;
  logic pready, pslverr, er, op_valid, op_mem, op_ready, op_done, res_we;
  logic greg0_we, rmw_lock, space_valid, shared_bank, stack_guard_en;
  logic [3:0] op_corr;
  logic [31:0] op_acc, op_src;
  logic [7:0] op_bval, greg0_data;
  logic [4:0] flag_val, flag_we, seen;
  cpual_op_e op_code;
  cpual_size_e op_size;
  cpual_space_e op_space, space_sel;
  cpual_breg_e op_breg;
  int cyc, errors = 0, checked = 0;
  always #10 clock = ~clock;
  cpual_core u_dut (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code),
    .op_size(op_size), .op_mem(op_mem), .op_corr(op_corr), .op_acc(op_acc),
    .op_src(op_src), .op_space(op_space), .op_breg(op_breg), .op_bval(op_bval),
    .op_ready(op_ready), .op_done(op_done), .res_data(res_data), .res_we(res_we),
    .greg0_data(greg0_data), .greg0_we(greg0_we), .flag_val(flag_val), .flag_we(flag_we),
    .rmw_lock(rmw_lock), .space_valid(space_valid), .space_sel(space_sel),
    .shared_bank(shared_bank), .stack_guard_en(stack_guard_en));
  cpual_seq_model u_seq (.clock(clock), .op_ready(op_ready), .op_done(op_done),
    .rmw_lock(rmw_lock), .shared_bank(shared_bank), .space_valid(space_valid),
    .space_sel(space_sel), .op_valid(op_valid), .op_code(op_code), .op_size(op_size),
    .op_mem(op_mem), .op_corr(op_corr), .op_acc(op_acc), .op_src(op_src),
    .op_space(op_space), .op_breg(op_breg), .op_bval(op_bval));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic run(input cpual_op_e c, input cpual_size_e s, input logic m,
    input logic [3:0] k, input logic [31:0] a, input logic [31:0] b, input logic [7:0] v);
    u_seq.issue(c, s, m, k, a, b, v, cyc, seen);
    if (cyc < 0) begin
      errors++;
      $display("[FAIL] op_done exp pulse got timeout");
      end_sim();
    end
  endtask : run
  // One idle cycle follows each transfer so psel is never driven twice in a step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    if (i == 16) begin
      errors++;
      $display("[FAIL] pready exp 1 got timeout");
      end_sim();
    end
  endtask : apb
  task automatic t_incdec();
    run(OP_ADD_ONE, SZ_BYTE, 1'b0, 4'h0, 32'h0, 32'h5a5a_5a7f, 8'h00);
    `CHK("inc byte", {INCDEC_BW_CYC, 8'h80, 3'b101, FM_NZV, 1'b1, 3'b000},
      {6'(cyc), res_data[7:0], flag_val[3:1], flag_we, res_we, seen[2:0]})
    run(OP_ADD_ONE, SZ_WORD, 1'b0, 4'h0, 32'h0, 32'h1234_ffff, 8'h00);
    `CHK("inc word", {16'h0, 3'b010}, {res_data[15:0], flag_val[3:1]})
    run(OP_SUB_ONE, SZ_LONG, 1'b1, 4'h3, 32'h0, 32'h0, 8'h00);
    `CHK("dec long mem", {INCDEC_L_CYC + 6'h03, 32'hffff_ffff, 3'b100, 1'b1},
      {6'(cyc), res_data, flag_val[3:1], seen[2]})
    $display("test incdec done");
  endtask : t_incdec
  task automatic t_cmp();
    run(OP_COMPARE, SZ_BYTE, 1'b0, 4'h0, 32'h0000_0010, 32'h0000_0020, 8'h00);
    `CHK("cmp byte", {CMP_BW_CYC, 4'b1001, FM_NZVC, 1'b0},
      {6'(cyc), flag_val[3:0], flag_we, res_we})
    run(OP_COMPARE, SZ_LONG, 1'b0, 4'h0, 32'h8000_0000, 32'h0000_0001, 8'h00);
    `CHK("cmp long", {CMP_L_CYC, 4'b0010}, {6'(cyc), flag_val[3:0]})
    run(OP_COMPARE, SZ_WORD, 1'b1, 4'h2, 32'h5555_1234, 32'haaaa_1234, 8'h00);
    `CHK("cmp word mem", {CMP_BW_CYC + 6'h02, 4'b0100}, {6'(cyc), flag_val[3:0]})
    $display("test compare done");
  endtask : t_cmp
  task automatic t_logic();
    cpual_op_e ops[3] = '{OP_LONG_AND, OP_LONG_OR, OP_LONG_XOR};
    logic [31:0] exp[3] = '{32'h0, 32'hffff_ffff, 32'hffff_ffff};
    for (int i = 0; i < 3; i++) begin
      run(ops[i], SZ_LONG, 1'b0, 4'h0, 32'h8000_f00f, 32'h7fff_0ff0, 8'h00);
      `CHK("long logic", {LOGIC_L_CYC, exp[i], i != 0, i == 0, 1'b0, FM_NZV, 1'b1},
        {6'(cyc), res_data, flag_val[3:1], flag_we, res_we})
    end
    $display("test logic done");
  endtask : t_logic
  task automatic t_norm();
    run(OP_NORMALIZE, SZ_LONG, 1'b0, 4'h0, 32'h0, 32'h0, 8'h00);
    `CHK("norm zero", {NORM_BASE_CYC, 1'b1, 8'h00, FM_T},
      {6'(cyc), flag_val[4], greg0_data, flag_we})
    run(OP_NORMALIZE, SZ_LONG, 1'b0, 4'h0, 32'h0000_1000, 32'h0, 8'h00);
    `CHK("norm shift", {NORM_BASE_CYC + 6'h13, 32'h8000_0000, 1'b0, 8'h13, 1'b1, FM_T},
      {6'(cyc), res_data, flag_val[4], greg0_data, greg0_we, flag_we})
    $display("test normalize done");
  endtask : t_norm
  task automatic t_scan();
    cpual_op_e ops[3] = '{OP_SCAN_INDEX, OP_SCAN_DOUBLED, OP_SCAN_QUAD};
    logic [5:0] zc[3] = '{SCAN1_ZERO_CYC, SCAN2_ZERO_CYC, SCAN4_ZERO_CYC};
    logic [5:0] sc[3] = '{SCAN1_SET_CYC, SCAN2_SET_CYC, SCAN4_SET_CYC};
    logic [7:0] pos[3] = '{8'h0a, 8'h14, 8'h28};
    for (int i = 0; i < 3; i++) begin
      run(ops[i], SZ_WORD, 1'b0, 4'h0, 32'habcd_0000, 32'h0, 8'h00);
      `CHK("scan zero", {zc[i], 8'h00, 1'b1, FM_Z},
        {6'(cyc), res_data[7:0], flag_val[2], flag_we})
      run(ops[i], SZ_WORD, 1'b0, 4'h0, 32'h0000_0400, 32'h0, 8'h00);
      `CHK("scan set", {sc[i], pos[i], 1'b0},
        {6'(cyc), res_data[7:0], flag_val[2]})
    end
    $display("test scan done");
  endtask : t_scan
  task automatic t_regs();
    apb(1'b0, CPUAL_RES_OFS, 32'h0);
    `CHK("result reg", {32'h0000_0028, 1'b0}, {rd, er})
    apb(1'b0, CPUAL_CTRL_OFS, 32'h0);
    `CHK("ctrl reset", CTRL_GUARD_RST, rd[CTRL_GUARD_BIT])
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("unmapped", {32'h0, 1'b1}, {rd, er})
    run(OP_GUARD_ON, SZ_BYTE, 1'b0, 4'h0, 32'h0, 32'h0, 8'h00);
    `CHK("guard on", {GUARD_CYC, 5'h00}, {6'(cyc), flag_we})
    apb(1'b0, CPUAL_STAT_OFS, 32'h0);
    `CHK("guard state", 2'b11, {rd[STAT_GUARD_BIT], stack_guard_en})
    run(OP_GUARD_OFF, SZ_BYTE, 1'b0, 4'h0, 32'h0, 32'h0, 8'h00);
    `CHK("guard off", {GUARD_CYC, 5'h00}, {6'(cyc), flag_we})
    apb(1'b0, CPUAL_CTRL_OFS, 32'h0);
    `CHK("guard cleared", 2'b00, {rd[CTRL_GUARD_BIT], stack_guard_en})
    apb(1'b1, CPUAL_CTRL_OFS, 32'h1);
    apb(1'b0, CPUAL_CTRL_OFS, 32'h0);
    `CHK("ctrl write", 2'b11, {rd[CTRL_GUARD_BIT], stack_guard_en})
    apb(1'b1, CPUAL_CTRL_OFS, 32'h0);
    $display("test registers done");
  endtask : t_regs
  task automatic t_prefix();
    run(OP_FLAG_HOLD, SZ_BYTE, 1'b0, 4'h0, 32'h0, 32'h0, 8'h00);
    `CHK("hold prefix", PREFIX_CYC, 6'(cyc))
    run(OP_ADD_ONE, SZ_BYTE, 1'b0, 4'h0, 32'h0, 32'h0, 8'h00);
    `CHK("held flags", {5'h00, 8'h01}, {flag_we, res_data[7:0]})
    run(OP_SHARED_BANK, SZ_BYTE, 1'b0, 4'h0, 32'h0, 32'h0, 8'h00);
    `CHK("shared prefix", PREFIX_CYC, 6'(cyc))
    run(OP_ADD_ONE, SZ_BYTE, 1'b0, 4'h0, 32'h0, 32'h0, 8'h00);
    `CHK("shared bank", 1'b1, seen[1])
    for (int s = 0; s < 4; s++) begin
      run(OP_SPACE_PREFIX, SZ_BYTE, 1'b0, 4'h0, 32'h0, 32'h0, 8'(s));
      `CHK("space cycles", PREFIX_CYC, 6'(cyc))
      run(OP_ADD_ONE, SZ_BYTE, 1'b1, 4'h1, 32'h0, 32'h0, 8'h00);
      `CHK("space prefix", {s[1:0], 1'b1}, {seen[4:3], seen[0]})
    end
    $display("test prefix done");
  endtask : t_prefix
  task automatic t_bank();
    logic [5:0] n;
    for (int b = 0; b < 7; b++) begin
      n = (b == BR_DATA) ? BANK_DATA_CYC : (b == BR_DIRECT_PAGE) ? BANK_PAGE_CYC : BANK_FAST_CYC;
      run(OP_MOV_BANK, SZ_BYTE, 1'b0, 4'h0, 32'h0, 32'h0, {5'h15, b[2:0]});
      `CHK("bank move", {n, 5'h15, b[2:0]}, {6'(cyc), res_data[7:0]})
    end
    $display("test bank done");
  endtask : t_bank
  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_incdec();
    t_cmp();
    t_logic();
    t_norm();
    t_scan();
    t_regs();
    t_prefix();
    t_bank();
    end_sim();
  end
endmodule : testbench
